// *** pkg/adc_seq_pkg.sv ***
// Shared constants, register map and state encoding of the converter channel sequencer.
package adc_seq_pkg;

  // Clock rates and the converter clock derived from the internal oscillator.
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned OSC_HZ = 1_228_800;
  localparam int unsigned OSC_DIVIDE = 16;
  localparam int unsigned CONV_CLK_HZ = OSC_HZ / OSC_DIVIDE;
  localparam int unsigned CONV_DIV_CYCLES = SYS_CLK_HZ / CONV_CLK_HZ;
  localparam int unsigned DIV_W = 10;
  localparam int unsigned MIN_CONV_TICKS = 20;

  // Sample rates in Hz.
  localparam int unsigned INTERNAL_RATE_HZ = 2560;
  localparam int unsigned RATE_A_HZ = 640;
  localparam int unsigned RATE_B_HZ = 1280;
  localparam int unsigned RATE_C_HZ = 2560;
  localparam int unsigned RATE_D_HZ = 3840;

  localparam int unsigned TICK_W = 8;

  // Converter clock ticks per slot, never below the least conversion time.
  function automatic logic [TICK_W-1:0] ticks_for(input int unsigned hz);
    int unsigned t;
    t = CONV_CLK_HZ / hz;
    if (t < MIN_CONV_TICKS) begin
      t = MIN_CONV_TICKS;
    end
    return TICK_W'(t);
  endfunction : ticks_for

  localparam logic [TICK_W-1:0] TICKS_INTERNAL = ticks_for(INTERNAL_RATE_HZ);
  localparam logic [TICK_W-1:0] TICKS_RATE_A = ticks_for(RATE_A_HZ);
  localparam logic [TICK_W-1:0] TICKS_RATE_B = ticks_for(RATE_B_HZ);
  localparam logic [TICK_W-1:0] TICKS_RATE_C = ticks_for(RATE_C_HZ);
  localparam logic [TICK_W-1:0] TICKS_RATE_D = ticks_for(RATE_D_HZ);

  localparam logic [1:0] RATE_CODE_A = 2'h0;
  localparam logic [1:0] RATE_CODE_B = 2'h1;
  localparam logic [1:0] RATE_CODE_C = 2'h2;
  localparam logic [1:0] RATE_CODE_D = 2'h3;

  // Widths.
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REG_W = 16;

  // Slot assignment.
  localparam logic [SLOT_W-1:0] SLOT_OFFSET = 4'h0;
  localparam logic [SLOT_W-1:0] SLOT_EXT0 = 4'h1;
  localparam logic [SLOT_W-1:0] SLOT_EXT1 = 4'h2;
  localparam logic [SLOT_W-1:0] SLOT_TEMP = 4'h3;
  localparam logic [SLOT_W-1:0] SLOT_DIAG_FIRST = 4'h4;
  localparam logic [SLOT_W-1:0] SLOT_DIAG_LAST = 4'h8;

  // Register addresses.
  localparam logic [ADDR_W-1:0] ADDR_SLOT_LIST = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_ADC_CFG = 8'h21;
  localparam logic [ADDR_W-1:0] ADDR_TRIGGER = 8'h22;
  localparam logic [ADDR_W-1:0] ADDR_GENERAL_FLAGS = 8'h23;
  localparam logic [ADDR_W-1:0] ADDR_EXT0_RESULT = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_EXT1_RESULT = 8'h25;
  localparam logic [ADDR_W-1:0] ADDR_TEMP_RESULT = 8'h26;
  localparam logic [ADDR_W-1:0] ADDR_DIAG_RESULT = 8'h27;
  localparam logic [ADDR_W-1:0] ADDR_OFFSET_CORR = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_BYPASS_CONTROL = 8'h2E;

  // Field positions.
  localparam int unsigned FIRST_LSB = 0;
  localparam int unsigned LAST_LSB = 4;
  localparam int unsigned CFG_SINGLE_BIT = 0;
  localparam int unsigned CFG_RATE_LSB = 1;
  localparam int unsigned CFG_SPAN_BIT = 3;
  localparam int unsigned TRIG_GO_BIT = 0;
  localparam int unsigned FLAG_ACTIVE_BIT = 0;
  localparam int unsigned BYP_SKIP_BIT = 0;

  // Reset and fixed values.
  localparam logic [SLOT_W-1:0] FIRST_RST = 4'h0;
  localparam logic [SLOT_W-1:0] LAST_RST = 4'h8;
  localparam logic [1:0] RATE_RST = 2'h2;
  localparam logic [DATA_W-1:0] OFFSET_MIDCODE = 12'h7FF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 12'h000;
  localparam logic [DATA_W-1:0] DATA_MAX = 12'hFFF;
  localparam logic [TICK_W-1:0] TICK_ZERO = 8'h00;
  localparam logic [TICK_W-1:0] TICK_ONE = 8'h01;
  localparam logic [SLOT_W-1:0] SLOT_ONE = 4'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAUNCH = 2'b01,
    ST_SAMPLE = 2'b11
  } seq_state_t;

endpackage : adc_seq_pkg

// *** hdl/conv_tick_divider.sv ***
// Divider that marks each converter clock period with a one-cycle enable.
`timescale 1ns/1ps
module conv_tick_divider
  import adc_seq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  output logic tick_o
);

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 10'h000;
  localparam logic [DIV_W-1:0] DIV_ONE = 10'h001;

  logic [DIV_W-1:0] cnt_r;
  logic tick_r;
  wire wrap = (cnt_r == DIV_LAST);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= DIV_ZERO;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= wrap ? DIV_ZERO : cnt_r + DIV_ONE;
      tick_r <= wrap;
    end
  end

  assign tick_o = tick_r;

endmodule : conv_tick_divider

// *** hdl/offset_corrector.sv ***
// Removes the stored offset correction from a raw conversion, clamped to the code range.
`timescale 1ns/1ps
module offset_corrector
  import adc_seq_pkg::*;
(
  input wire logic [DATA_W-1:0] raw_i,
  input wire logic [DATA_W-1:0] offset_i,
  input wire logic skip_i,
  output logic [DATA_W-1:0] corr_o
);

  // Two guard bits hold the full span of a code minus a signed correction.
  logic signed [DATA_W+1:0] diff;

  assign diff = $signed({2'b00, raw_i}) - $signed({{2{offset_i[DATA_W-1]}}, offset_i});
  assign corr_o = skip_i ? raw_i :
                  diff[DATA_W+1] ? DATA_ZERO :
                  diff[DATA_W] ? DATA_MAX : diff[DATA_W-1:0];

endmodule : offset_corrector

// *** hdl/adc_channel_sequencer.sv ***
// Channel sequencer of the diagnostic converter with its configuration and result registers.
// Notes on behaviour
// - Sixteen slots; only slots from first to last field are converted.
// - Single-pass converts first through last once per trigger, then idles.
// - Continuous mode restarts at first slot after last, until stopped.
// - Slot order fixed: offset, two external inputs, temperature, five diagnostics, ground.
// - Equal first and last converts just that slot, else every slot between.
// - Reset leaves first field at 0 and last field at 8.
// - Unused external input 1 reads zero but still takes its slot time.
// - First above last behaves as if last equalled first.
// - Continuous: go=1 starts, go=0 stops after the current slot finishes.
// - Single-pass: go=1 starts one pass; hardware clears go at pass end.
// - Each slot lasts at least 20 converter clocks of oscillator over 16.
// - Internal slots always run at the fixed 2560 Hz rate.
// - External inputs run at 640, 1280, 2560 or 3840 Hz by field.
// - Span bit 0 gives wide span on external inputs, 1 narrow; low supply forces narrow.
// - Under low output-stage supply software cannot select the wide span.
// - Idle until go is written; in single-pass go and active show idle.
// - Result registers keep latest results; reads never disturb conversions.
// - Slot 0 stores 7FFh minus raw result as two's complement correction.
// - Correction is subtracted from conversions unless offset skip is set.
// - External results are 12-bit straight binary codes.
// - Results land at 24h, 25h, 26h and 27h after each conversion.
`timescale 1ns/1ps
module adc_channel_sequencer
  import adc_seq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [REG_W-1:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [REG_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic output_stage_low_i,
  input wire logic ext_input1_used_i,
  input wire logic conv_done_i,
  input wire logic [DATA_W-1:0] conv_data_i,
  output logic [SLOT_W-1:0] mux_slot_o,
  output logic conv_start_o,
  output logic conv_span_wide_o,
  output logic conv_active_o
);

  function automatic logic is_ext(input logic [SLOT_W-1:0] s);
    return (s == SLOT_EXT0) || (s == SLOT_EXT1);
  endfunction : is_ext

  // Slot length in converter clocks; internal nodes ignore the rate field.
  function automatic logic [TICK_W-1:0] slot_ticks(input logic [SLOT_W-1:0] s,
                                                   input logic [1:0] rate);
    logic [TICK_W-1:0] t;
    t = TICKS_INTERNAL;
    if (is_ext(s)) begin
      case (rate)
        RATE_CODE_A: t = TICKS_RATE_A;
        RATE_CODE_B: t = TICKS_RATE_B;
        RATE_CODE_C: t = TICKS_RATE_C;
        RATE_CODE_D: t = TICKS_RATE_D;
        default: t = TICKS_INTERNAL;
      endcase
    end
    return t;
  endfunction : slot_ticks

  logic [SLOT_W-1:0] first_r;
  logic [SLOT_W-1:0] last_r;
  logic single_r;
  logic [1:0] rate_r;
  logic span_r;
  logic skip_r;
  logic go_r;
  logic go_nxt;
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [SLOT_W-1:0] slot_r;
  logic [SLOT_W-1:0] slot_nxt;
  logic [TICK_W-1:0] tick_cnt_r;
  logic [DATA_W-1:0] raw_r;
  logic [DATA_W-1:0] ext0_r;
  logic [DATA_W-1:0] ext1_r;
  logic [DATA_W-1:0] temp_r;
  logic [DATA_W-1:0] diag_r;
  logic [DATA_W-1:0] offset_r;
  logic start_r;
  logic span_wide_r;
  logic active_r;
  logic [REG_W-1:0] rdata_r;
  logic rvalid_r;
  logic conv_tick;
  logic [DATA_W-1:0] corr;

  conv_tick_divider u_div (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_o(conv_tick)
  );

  offset_corrector u_corr (
    .raw_i(raw_r),
    .offset_i(offset_r),
    .skip_i(skip_r),
    .corr_o(corr)
  );

  // Register write decode.
  wire wr_list = reg_wr_i && (reg_addr_i == ADDR_SLOT_LIST);
  wire wr_cfg = reg_wr_i && (reg_addr_i == ADDR_ADC_CFG);
  wire wr_trig = reg_wr_i && (reg_addr_i == ADDR_TRIGGER);
  wire wr_byp = reg_wr_i && (reg_addr_i == ADDR_BYPASS_CONTROL);
  wire go_wr_val = reg_wdata_i[TRIG_GO_BIT];

  wire [SLOT_W-1:0] eff_last = (last_r < first_r) ? first_r : last_r;
  wire [TICK_W-1:0] slot_len = slot_ticks(slot_r, rate_r);
  wire in_sample = (state_r == ST_SAMPLE);
  wire slot_end = in_sample && conv_tick && (tick_cnt_r == slot_len - TICK_ONE);
  wire at_last = (slot_r == eff_last);
  wire pass_clear = slot_end && at_last && single_r;
  wire busy = (state_r != ST_IDLE);

  // A zero written during a single pass is ignored so go keeps showing the pass.
  wire go_wr_take = wr_trig && (go_wr_val || !(single_r && busy));
  // Software write is applied over the hardware clear, so a set in that cycle survives.
  assign go_nxt = go_wr_take ? go_wr_val : (pass_clear ? 1'b0 : go_r);

  // Sequencing of slots.
  always_comb begin
    state_nxt = state_r;
    slot_nxt = slot_r;
    case (state_r)
      ST_IDLE: begin
        if (go_r) begin
          state_nxt = ST_LAUNCH;
          slot_nxt = first_r;
        end
      end
      ST_LAUNCH: begin
        state_nxt = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        if (slot_end) begin
          if (at_last) begin
            if (single_r || !go_r) begin
              state_nxt = ST_IDLE;
            end else begin
              state_nxt = ST_LAUNCH;
              slot_nxt = first_r;
            end
          end else if (!single_r && !go_r) begin
            state_nxt = ST_IDLE;
          end else begin
            state_nxt = ST_LAUNCH;
            slot_nxt = slot_r + SLOT_ONE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Span control: the wide span is only ever offered to an external input.
  wire span_wr_val = reg_wdata_i[CFG_SPAN_BIT] | output_stage_low_i;
  wire span_wide_nxt = !span_r && !output_stage_low_i && is_ext(slot_nxt);

  // Result commit at the close of each slot.
  wire commit = slot_end;
  wire [DATA_W-1:0] ext1_val = ext_input1_used_i ? corr : DATA_ZERO;
  wire [DATA_W-1:0] offset_val = OFFSET_MIDCODE - raw_r;
  wire is_diag = (slot_r >= SLOT_DIAG_FIRST) && (slot_r <= SLOT_DIAG_LAST);

  // Read mux; the read path touches no sequencing state.
  wire [REG_W-1:0] rd_word =
    (reg_addr_i == ADDR_SLOT_LIST) ? {8'h00, last_r, first_r} :
    (reg_addr_i == ADDR_ADC_CFG) ? {12'h000, span_r, rate_r, single_r} :
    (reg_addr_i == ADDR_TRIGGER) ? {15'h0000, go_r} :
    (reg_addr_i == ADDR_GENERAL_FLAGS) ? {15'h0000, active_r} :
    (reg_addr_i == ADDR_EXT0_RESULT) ? {4'h0, ext0_r} :
    (reg_addr_i == ADDR_EXT1_RESULT) ? {4'h0, ext1_r} :
    (reg_addr_i == ADDR_TEMP_RESULT) ? {4'h0, temp_r} :
    (reg_addr_i == ADDR_DIAG_RESULT) ? {4'h0, diag_r} :
    (reg_addr_i == ADDR_OFFSET_CORR) ? {4'h0, offset_r} :
    (reg_addr_i == ADDR_BYPASS_CONTROL) ? {15'h0000, skip_r} : 16'h0000;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      first_r <= FIRST_RST;
      last_r <= LAST_RST;
      single_r <= 1'b0;
      rate_r <= RATE_RST;
      span_r <= 1'b0;
      skip_r <= 1'b0;
    end else begin
      if (wr_list) begin
        first_r <= reg_wdata_i[FIRST_LSB +: SLOT_W];
        last_r <= reg_wdata_i[LAST_LSB +: SLOT_W];
      end
      if (wr_cfg) begin
        single_r <= reg_wdata_i[CFG_SINGLE_BIT];
        rate_r <= reg_wdata_i[CFG_RATE_LSB +: 2];
        span_r <= span_wr_val;
      end
      if (wr_byp) begin
        skip_r <= reg_wdata_i[BYP_SKIP_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      go_r <= 1'b0;
      state_r <= ST_IDLE;
      slot_r <= SLOT_OFFSET;
      tick_cnt_r <= TICK_ZERO;
      start_r <= 1'b0;
      span_wide_r <= 1'b0;
      active_r <= 1'b0;
    end else begin
      go_r <= go_nxt;
      state_r <= state_nxt;
      slot_r <= slot_nxt;
      if (state_r == ST_LAUNCH) begin
        tick_cnt_r <= TICK_ZERO;
      end else if (in_sample && conv_tick) begin
        tick_cnt_r <= tick_cnt_r + TICK_ONE;
      end
      start_r <= (state_nxt == ST_LAUNCH);
      span_wide_r <= span_wide_nxt;
      active_r <= (state_nxt != ST_IDLE);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      raw_r <= DATA_ZERO;
      ext0_r <= DATA_ZERO;
      ext1_r <= DATA_ZERO;
      temp_r <= DATA_ZERO;
      diag_r <= DATA_ZERO;
      offset_r <= DATA_ZERO;
    end else begin
      if (in_sample && conv_done_i) begin
        raw_r <= conv_data_i;
      end
      if (commit) begin
        if (slot_r == SLOT_OFFSET) begin
          offset_r <= offset_val;
        end
        if (slot_r == SLOT_EXT0) begin
          ext0_r <= corr;
        end
        if (slot_r == SLOT_EXT1) begin
          ext1_r <= ext1_val;
        end
        if (slot_r == SLOT_TEMP) begin
          temp_r <= corr;
        end
        if (is_diag) begin
          diag_r <= corr;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_r <= rd_word;
      end
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;
  assign mux_slot_o = slot_r;
  assign conv_start_o = start_r;
  assign conv_span_wide_o = span_wide_r;
  assign conv_active_o = active_r;

  // Helper count of cycles since the last conversion launch, for the timing check.
  localparam int MIN_GAP = (MIN_CONV_TICKS - 1) * CONV_DIV_CYCLES;
  logic [15:0] since_start_r;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      since_start_r <= 16'hFFFF;
    end else if (start_r) begin
      since_start_r <= 16'h0001;
    end else if (since_start_r != 16'hFFFF) begin
      since_start_r <= since_start_r + 16'h0001;
    end
  end

  chk_slot_range: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    conv_start_o |-> (mux_slot_o >= first_r) && (mux_slot_o <= eff_last))
    else $error("slot launched outside the selected range");

  chk_single_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (pass_clear && !wr_trig) |=> !go_r && state_r == ST_IDLE ##1 !conv_active_o)
    else $error("single pass did not clear go and return to idle");

  chk_auto_wrap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (slot_end && at_last && !single_r && go_r) |=> conv_start_o && mux_slot_o == first_r)
    else $error("continuous pass did not restart at the first slot");

  chk_stop_finish: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (in_sample && !slot_end && $fell(go_r)) |=> in_sample && $stable(slot_r))
    else $error("stop request cut the current slot short");

  chk_min_time: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (conv_start_o && since_start_r != 16'hFFFF) |-> since_start_r > MIN_GAP)
    else $error("slot shorter than the least conversion time");

  chk_ext1_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && slot_r == SLOT_EXT1 && !ext_input1_used_i) |=> ext1_r == DATA_ZERO)
    else $error("unused external input 1 result not zero");

  chk_offset_calc: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (commit && slot_r == SLOT_OFFSET) |=> offset_r == OFFSET_MIDCODE - $past(raw_r))
    else $error("offset correction not midcode minus raw");

  chk_span_narrow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ($past(output_stage_low_i) || $past(span_r)) |-> !conv_span_wide_o)
    else $error("wide span offered while narrow is required");

  chk_span_block: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_cfg && output_stage_low_i) |=> span_r)
    else $error("wide span accepted under low supply");

  chk_idle_start: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ST_IDLE && !go_r) |=> !conv_start_o && !conv_active_o)
    else $error("sequencer left idle without go");

  chk_active_trig: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (state_r == ST_IDLE && go_r) |=> conv_active_o && conv_start_o)
    else $error("active flag or launch missing after trigger");

endmodule : adc_channel_sequencer

// *** bench/converter_core_model.sv ***
// Behavioural converter core that answers each slot launch with a raw code.
`timescale 1ns/1ps
module converter_core_model
  import adc_seq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic conv_start_i,
  input wire logic [SLOT_W-1:0] mux_slot_i,
  output logic conv_done_o,
  output logic [DATA_W-1:0] conv_data_o
);
  int unsigned wait_r;
  logic [SLOT_W-1:0] slot_r;
  logic [DATA_W-1:0] code_w;

  // Slot 0 sits just below midcode, so a small positive correction results.
  assign code_w = (slot_r == SLOT_OFFSET) ? 12'h7F0 : {slot_r, 8'h00};

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_r <= 0;
      slot_r <= 4'h0;
      conv_done_o <= 1'b0;
      conv_data_o <= 12'h000;
    end else begin
      conv_done_o <= 1'b0;
      // Outside the result pulse the lines toggle, so a stale code is never mistaken for data.
      conv_data_o <= ~conv_data_o;
      if (conv_start_i) begin
        slot_r <= mux_slot_i;
        wait_r <= slow_i ? 2000 : 20;
      end else if (wait_r == 1) begin
        conv_done_o <= 1'b1;
        conv_data_o <= code_w;
        wait_r <= 0;
      end else if (wait_r != 0) begin
        wait_r <= wait_r - 1;
      end
    end
  end
endmodule : converter_core_model

// *** bench/tb_top.sv ***
// Self-checking testbench of the converter channel sequencer.
`timescale 1ns/1ps
module tb_top;
  import adc_seq_pkg::*;
  logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, output_stage_low_i, ext_input1_used_i, slow;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [REG_W-1:0] reg_wdata_i, reg_rdata_o;
  logic reg_rvalid_o, conv_done_i, conv_start_o, conv_span_wide_o, conv_active_o;
  logic [DATA_W-1:0] conv_data_i;
  logic [SLOT_W-1:0] mux_slot_o;
  int unsigned miscompares, total_checks, cyc, idle_t;
  logic [3:0] slots[$];
  int unsigned start_t[$];
  logic span_seen;
  localparam int unsigned D = CONV_DIV_CYCLES;
  localparam int unsigned NINT = CONV_CLK_HZ / INTERNAL_RATE_HZ;
  localparam int unsigned NEXT = CONV_CLK_HZ / RATE_D_HZ;

  adc_channel_sequencer adc_channel_sequencer_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .output_stage_low_i(output_stage_low_i), .ext_input1_used_i(ext_input1_used_i),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .mux_slot_o(mux_slot_o),
    .conv_start_o(conv_start_o), .conv_span_wide_o(conv_span_wide_o),
    .conv_active_o(conv_active_o));
  converter_core_model converter_core_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .slow_i(slow), .conv_start_i(conv_start_o), .mux_slot_i(mux_slot_o),
    .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // Launch monitor: records slot and time of every slot start, and the span of the latest one.
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (conv_start_o === 1'b1) begin
      slots.push_back(mux_slot_o);
      start_t.push_back(cyc);
      span_seen = conv_span_wide_o;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check({15'h0, reg_rvalid_o}, 16'h0001);
    check(reg_rdata_o, exp);
  endtask : rd_chk

  task automatic trigger_and_wait();
    slots.delete();
    start_t.delete();
    wr(ADDR_TRIGGER, 16'h0001);
    repeat (3) @(posedge ref_clk_i);
    for (int n = 0; n < 60000 && conv_active_o !== 1'b0; n++) @(posedge ref_clk_i);
    idle_t = cyc;
    check({15'h0, conv_active_o}, 16'h0000);
  endtask : trigger_and_wait

  task automatic reset_values();
    rd_chk(ADDR_SLOT_LIST, 16'h0080);
    rd_chk(ADDR_ADC_CFG, 16'h0004);
    rd_chk(ADDR_GENERAL_FLAGS, 16'h0000);
    wr(ADDR_OFFSET_CORR, 16'h0ABC);
    rd_chk(ADDR_OFFSET_CORR, 16'h0000);
    rd_chk(8'h30, 16'h0000);
  endtask : reset_values

  task automatic single_pass_offset();
    wr(ADDR_SLOT_LIST, 16'h0010);
    wr(ADDR_ADC_CFG, 16'h0007);
    trigger_and_wait();
    check(16'(slots.size()), 16'h0002);
    check(16'(slots[0]), 16'h0000);
    check(16'(slots[1]), 16'h0001);
    check(16'(start_t[1] - start_t[0] >= (NINT - 1) * D && start_t[1] - start_t[0] <= NINT * D + 2),
      16'h0001);
    check(16'(idle_t - start_t[1] >= (NEXT - 1) * D && idle_t - start_t[1] <= NEXT * D + 8),
      16'h0001);
    rd_chk(ADDR_OFFSET_CORR, 16'h000F);
    rd_chk(ADDR_EXT0_RESULT, 16'h00F1);
    rd_chk(ADDR_TRIGGER, 16'h0000);
  endtask : single_pass_offset

  task automatic reversed_range_low_supply();
    @(posedge ref_clk_i);
    output_stage_low_i <= 1'b1;
    ext_input1_used_i <= 1'b0;
    wr(ADDR_SLOT_LIST, 16'h0012);
    wr(ADDR_ADC_CFG, 16'h0007);
    rd_chk(ADDR_ADC_CFG, 16'h000F);
    trigger_and_wait();
    check(16'(slots.size()), 16'h0001);
    check(16'(slots[0]), 16'h0002);
    check(16'(idle_t - start_t[0] >= (NEXT - 1) * D), 16'h0001);
    check({15'h0, span_seen}, 16'h0000);
    rd_chk(ADDR_EXT1_RESULT, 16'h0000);
  endtask : reversed_range_low_supply

  task automatic continuous_stop();
    // Reconfiguration only happens with the sequencer idle.
    @(posedge ref_clk_i);
    output_stage_low_i <= 1'b0;
    slow <= 1'b1;
    wr(ADDR_SLOT_LIST, 16'h0011);
    wr(ADDR_ADC_CFG, 16'h0006);
    wr(ADDR_BYPASS_CONTROL, 16'h0001);
    slots.delete();
    start_t.delete();
    wr(ADDR_TRIGGER, 16'h0001);
    // The one-slot pass must wrap once before the stop request goes in.
    for (int n = 0; n < 15000 && slots.size() < 2; n++) @(posedge ref_clk_i);
    wr(ADDR_TRIGGER, 16'h0000);
    repeat (2) @(posedge ref_clk_i);
    check({15'h0, conv_active_o}, 16'h0001);
    for (int n = 0; n < 60000 && conv_active_o !== 1'b0; n++) @(posedge ref_clk_i);
    repeat (700) @(posedge ref_clk_i);
    check(16'(slots.size()), 16'h0002);
    check(16'(slots[1]), 16'h0001);
    check(16'(start_t[1] - start_t[0] >= (NEXT - 1) * D && start_t[1] - start_t[0] <= NEXT * D + 2),
      16'h0001);
    check({15'h0, span_seen}, 16'h0001);
    rd_chk(ADDR_EXT0_RESULT, 16'h0100);
  endtask : continuous_stop

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    #1900000;
    miscompares++;
    test_done();
  end

  initial begin
    rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    output_stage_low_i = 1'b0;
    ext_input1_used_i = 1'b1;
    slow = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    reset_values();
    single_pass_offset();
    reversed_range_low_supply();
    continuous_stop();
    test_done();
  end
endmodule : tb_top
